// ---- rtl/phy_an_cfg.svh ----
/*
  Offsets, field positions, reset values and timing counts for the
  auto-negotiation and vendor configuration register bank.
  Assumes 5-bit management register addresses and 16-bit data words.
*/
`ifndef PHY_AN_CFG_SVH
`define PHY_AN_CFG_SVH

// Register addresses on the management port
`define REG_BASIC_CTRL 5'h00
`define REG_ADVERT 5'h04
`define REG_PARTNER 5'h05
`define REG_EXPANSION 5'h06
`define REG_VCFG 5'h10
`define REG_VSTAT 5'h11

// Basic control fields
`define BCTRL_SPEED 13
`define BCTRL_AN_EN 12
`define BCTRL_DUPLEX 8
`define BCTRL_RESET 16'h3100
`define BCTRL_WMASK 16'h3100

// Ability word fields, shared by advert and partner registers
`define ADV_NP 15
`define ADV_ACK 14
`define ADV_T4 9
`define ADV_RESET 16'h05e1
`define ADV_WMASK 16'h3dff
`define PARTNER_RMASK 16'he7ff

// Expansion fields
`define EXP_PDF 4
`define EXP_LP_NP 3
`define EXP_LOCAL_NEXT_PAGE_CAPABLE 2
`define EXP_PAGE_RX 1
`define EXP_LP_AN 0

// Vendor configuration fields
`define VCFG_BP_CODER 15
`define VCFG_BYPASS_SCRAMBLER 14
`define VCFG_BP_PATH 13
`define VCFG_FORCE_SD 12
`define VCFG_COPPER 10
`define VCFG_FORCE_LINK 7
`define VCFG_ARPD_EN 4
`define VCFG_SM_RST 3
`define VCFG_SLEEP 1
`define VCFG_LOOPOUT 0
`define VCFG_RESET 16'h0414
`define VCFG_WMASK 16'hfdff

// Vendor status result field, bits 15..12
`define VSTAT_RESET 4'hf

// State machine reset pulse length
`define CLK_MHZ 25
`define STATE_MACHINE_RESET_TIME_NS 1000
`define STATE_MACHINE_RESET_CYCLES ((`STATE_MACHINE_RESET_TIME_NS * `CLK_MHZ + 999) / 1000)

`endif

// ---- rtl/phy_an_pkg.sv ----
/*
  Types for the auto-negotiation register bank: the control bundle that
  steers the transceiver and the single state record of the bank.
  Widths are written out here, not taken from phy_an_cfg.svh.
*/
package phy_an_pkg;

  // Control levels handed to the transceiver datapath
  typedef struct packed {
    logic bypass_symbol_coder;
    logic bypass_scrambler;
    logic bypass_symbol_path;
    logic force_signal_detect;
    logic copper_mode;
    logic force_fast_link;
    logic auto_reduced_powerdown_en;
    logic state_machine_reset;
    logic sleep_mode;
    logic remote_loopback;
    logic an_enable;
  } ctrl_t;

  // Whole state of the bank
  typedef struct packed {
    logic [15:0] bctrl;
    logic [15:0] advert;
    logic [15:0] partner;
    logic parallel_detect_fault;
    logic page_received;
    logic partner_next_page_capable;
    logic partner_negotiation_capable;
    logic [15:0] vcfg;
    logic [3:0] vstat;
    logic an_done;
    logic tx_ack;
    logic [7:0] rst_cnt;
    logic [15:0] tx_word;
    logic [15:0] rdata;
    logic rvalid;
  } state_t;

endpackage : phy_an_pkg

// ---- rtl/phy_autoneg_config_registers.sv ----
/*
  Auto-negotiation advertisement, link partner ability, expansion and
  vendor configuration/status registers of a 10/100 transceiver, with a
  small basic control register for the negotiation enable.
  Assumes a management port on mclk with one-cycle read and write
  strobes, and an auto-negotiation engine on the same clock that
  reports received pages, faults and the final result as pulses.
*/
// Notes on behaviour
// RULE1 - Advertised next-page bit always reads zero; no next page is offered.
// RULE2 - Negotiation engine drives the outgoing acknowledge bit, not software.
// RULE3 - Advertised remote-fault bit is writable, resets to zero.
// RULE4 - Software writes zero to reserved advert bits 12-11, ignores reads.
// RULE5 - Advertised pause capability bit is read/write, resets to one.
// RULE6 - Advertised four-pair capability bit is a permanent zero.
// RULE7 - Four advertised speed/duplex bits are read/write, each reset to one.
// RULE8 - Selector field is read/write, resets to 00001.
// RULE9 - Partner ability register is read-only, zero at reset, loaded per page.
// RULE10 - Partner acknowledge bit comes from received pages only.
// RULE11 - Parallel detection fault bit latches high, read-only, resets zero.
// RULE12 - Expansion reports partner next-page and negotiation ability, read-only.
// RULE13 - Local next-page-able bit always reads zero.
// RULE14 - Page-received bit sets on a new page, clears on expansion read.
// RULE15 - Vendor bits 15..13 bypass coder, scrambler, whole symbol path.
// RULE16 - Vendor bit 12 forces signal detect OK for debug.
// RULE17 - Vendor bit 10 selects copper when one, fibre when zero.
// RULE18 - Vendor bit 7 forces good 100 Mbps link status.
// RULE19 - Vendor bit 4 enables automatic reduced power-down, resets to one.
// RULE20 - Writing vendor bit 3 resets state machines, self-clears after.
// RULE21 - Vendor bit 1 enters sleep; clearing it resets state machines.
// RULE22 - Vendor bit 0 loops received data out to transmit.
// RULE23 - Status bits 15..12 take negotiated mode when negotiation completes.
// RULE24 - Basic control bit 12 enables negotiation; speed, duplex show result.
// RULE25 - Reserved read-only bits read zero and ignore writes.
`timescale 1ns/100ps
`include "phy_an_cfg.svh"

module phy_autoneg_config_registers
  import phy_an_pkg::*;
(
  // Clock and reset
  input logic mclk,
  input logic rstn,
  // Management register port
  input logic [4:0] mgmt_addr,
  input logic [15:0] mgmt_wdata,
  input logic mgmt_write,
  input logic mgmt_read,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_rvalid,
  // Negotiation engine events
  input logic an_page_valid,
  input logic [15:0] an_page_word,
  input logic an_tx_ack,
  input logic an_pd_fault,
  input logic an_complete,
  input logic [3:0] an_result,
  // Outgoing base page and datapath controls
  output logic [15:0] adv_tx_word,
  output ctrl_t ctrl
);

  state_t st;
  state_t next_st;

  logic wr_bctrl;
  logic wr_advert;
  logic wr_vcfg;
  logic rd_expansion;
  logic sleep_exit;
  logic state_machine_reset_req;
  logic [15:0] adv_view;
  logic [15:0] vcfg_view;
  logic [15:0] bctrl_view;
  logic [15:0] exp_view;
  logic [15:0] rd_mux;

  // Write and read decode
  assign wr_bctrl = mgmt_write && (mgmt_addr == `REG_BASIC_CTRL);
  assign wr_advert = mgmt_write && (mgmt_addr == `REG_ADVERT);
  assign wr_vcfg = mgmt_write && (mgmt_addr == `REG_VCFG);
  assign rd_expansion = mgmt_read && (mgmt_addr == `REG_EXPANSION);

  // Leaving sleep and the self-clearing bit both restart the machines
  assign sleep_exit = wr_vcfg && st.vcfg[`VCFG_SLEEP] &&
                      !mgmt_wdata[`VCFG_SLEEP]; // [RULE21]
  assign state_machine_reset_req = (wr_vcfg && mgmt_wdata[`VCFG_SM_RST]) ||
                     sleep_exit; // [RULE20]

  // Advertisement as software sees it; fixed bits forced here
  always_comb begin
    adv_view = st.advert;
    adv_view[`ADV_NP] = 1'b0; // [RULE1]
    adv_view[`ADV_ACK] = st.tx_ack; // [RULE2]
    adv_view[`ADV_T4] = 1'b0; // [RULE6]
  end

  // Vendor configuration readback; bit 3 shows a reset in progress
  always_comb begin
    vcfg_view = st.vcfg;
    vcfg_view[`VCFG_SM_RST] = (st.rst_cnt != 8'h00); // [RULE20]
  end

  // Basic control shows the negotiated speed and duplex when enabled and a result is held
  always_comb begin
    bctrl_view = st.bctrl;
    if (st.bctrl[`BCTRL_AN_EN] && st.an_done) begin
      bctrl_view[`BCTRL_SPEED] = st.vstat[3] | st.vstat[2]; // [RULE24]
      bctrl_view[`BCTRL_DUPLEX] = st.vstat[3] | st.vstat[1]; // [RULE24]
    end
  end

  // Expansion word; everything above bit 4 is reserved zero
  always_comb begin
    exp_view = 16'h0000; // [RULE25]
    exp_view[`EXP_PDF] = st.parallel_detect_fault; // [RULE11]
    exp_view[`EXP_LP_NP] = st.partner_next_page_capable; // [RULE12]
    exp_view[`EXP_LOCAL_NEXT_PAGE_CAPABLE] = 1'b0; // [RULE13]
    exp_view[`EXP_PAGE_RX] = st.page_received; // [RULE14]
    exp_view[`EXP_LP_AN] = st.partner_negotiation_capable; // [RULE12]
  end

  // Read multiplexer; unmapped addresses read as zero
  always_comb begin
    unique case (mgmt_addr)
      `REG_BASIC_CTRL: rd_mux = bctrl_view;
      `REG_ADVERT: rd_mux = adv_view;
      `REG_PARTNER: rd_mux = st.partner;
      `REG_EXPANSION: rd_mux = exp_view;
      `REG_VCFG: rd_mux = vcfg_view;
      `REG_VSTAT: rd_mux = {st.vstat, 12'h000}; // [RULE25]
      default: rd_mux = 16'h0000;
    endcase
  end

  // Next state of the whole bank
  always_comb begin
    next_st = st;
    next_st.rvalid = mgmt_read;
    if (mgmt_read) begin
      next_st.rdata = rd_mux;
    end

    // Basic control: only the enable and the manual speed/duplex store
    if (wr_bctrl) begin
      next_st.bctrl = (st.bctrl & ~`BCTRL_WMASK) |
                      (mgmt_wdata & `BCTRL_WMASK); // [RULE24]
    end

    // Advertisement: fixed bits are outside the write mask
    if (wr_advert) begin
      next_st.advert = (st.advert & ~`ADV_WMASK) |
                       (mgmt_wdata & `ADV_WMASK); // [RULE3] [RULE5] [RULE7] [RULE8]
    end

    // Acknowledge bit follows the engine every cycle
    next_st.tx_ack = an_tx_ack; // [RULE2]

    // Partner page capture; reserved bits 12-11 kept at zero
    if (an_page_valid) begin
      next_st.partner = an_page_word & `PARTNER_RMASK; // [RULE9] [RULE10]
      next_st.partner_next_page_capable = an_page_word[`ADV_NP]; // [RULE12]
      next_st.partner_negotiation_capable = 1'b1; // [RULE12]
    end

    // Sticky flags clear on an expansion read; a same-cycle event wins
    if (rd_expansion) begin
      next_st.page_received = 1'b0; // [RULE14]
      next_st.parallel_detect_fault = 1'b0;
    end
    if (an_page_valid) begin
      next_st.page_received = 1'b1; // [RULE14]
    end
    if (an_pd_fault) begin
      next_st.parallel_detect_fault = 1'b1; // [RULE11]
    end

    // Vendor configuration; bit 9 stays a read-only zero
    if (wr_vcfg) begin
      next_st.vcfg = (st.vcfg & ~`VCFG_WMASK) |
                     (mgmt_wdata & `VCFG_WMASK); // [RULE15] [RULE22]
    end

    // Self-timed machine reset; bit 3 drops when the count runs out
    if (state_machine_reset_req) begin
      next_st.rst_cnt = 8'(`STATE_MACHINE_RESET_CYCLES); // [RULE20] [RULE21]
    end else if (st.rst_cnt != 8'h00) begin
      next_st.rst_cnt = st.rst_cnt - 8'h01;
    end
    next_st.vcfg[`VCFG_SM_RST] = (next_st.rst_cnt != 8'h00); // [RULE20]

    // Negotiated mode lands in the status field on a completion while negotiation is enabled
    if (an_complete && st.bctrl[`BCTRL_AN_EN]) begin
      next_st.vstat = an_result; // [RULE23]
      next_st.an_done = 1'b1;
    end
    // A machine reset or a disabled negotiation voids the result
    if (state_machine_reset_req || !next_st.bctrl[`BCTRL_AN_EN]) begin
      next_st.an_done = 1'b0; // [RULE24]
    end

    // Outgoing base page, registered so the engine sees a clean word
    next_st.tx_word = next_st.advert;
    next_st.tx_word[`ADV_NP] = 1'b0; // [RULE1]
    next_st.tx_word[`ADV_ACK] = an_tx_ack; // [RULE2]
    next_st.tx_word[`ADV_T4] = 1'b0; // [RULE6]
  end

  // State register; every field has a constant reset value
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st.bctrl <= `BCTRL_RESET; // [RULE24]
      st.advert <= `ADV_RESET; // [RULE3] [RULE5] [RULE7] [RULE8]
      st.partner <= 16'h0000; // [RULE9]
      st.parallel_detect_fault <= 1'b0;
      st.page_received <= 1'b0;
      st.partner_next_page_capable <= 1'b0;
      st.partner_negotiation_capable <= 1'b0;
      st.vcfg <= `VCFG_RESET; // [RULE17] [RULE19]
      st.vstat <= `VSTAT_RESET;
      st.an_done <= 1'b0;
      st.tx_ack <= 1'b0;
      st.rst_cnt <= 8'h00;
      st.tx_word <= 16'h0000;
      st.rdata <= 16'h0000;
      st.rvalid <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Management answer comes straight from flip-flops
  assign mgmt_rdata = st.rdata;
  assign mgmt_rvalid = st.rvalid;
  assign adv_tx_word = st.tx_word;

  // Datapath controls; all are register bits, so they are glitch free
  assign ctrl.bypass_symbol_coder = st.vcfg[`VCFG_BP_CODER]; // [RULE15]
  assign ctrl.bypass_scrambler = st.vcfg[`VCFG_BYPASS_SCRAMBLER]; // [RULE15]
  assign ctrl.bypass_symbol_path = st.vcfg[`VCFG_BP_PATH]; // [RULE15]
  assign ctrl.force_signal_detect = st.vcfg[`VCFG_FORCE_SD]; // [RULE16]
  assign ctrl.copper_mode = st.vcfg[`VCFG_COPPER]; // [RULE17]
  assign ctrl.force_fast_link = st.vcfg[`VCFG_FORCE_LINK]; // [RULE18]
  assign ctrl.auto_reduced_powerdown_en = st.vcfg[`VCFG_ARPD_EN]; // [RULE19]
  assign ctrl.state_machine_reset = st.vcfg[`VCFG_SM_RST]; // [RULE20]
  assign ctrl.sleep_mode = st.vcfg[`VCFG_SLEEP]; // [RULE21]
  assign ctrl.remote_loopback = st.vcfg[`VCFG_LOOPOUT]; // [RULE22]
  assign ctrl.an_enable = st.bctrl[`BCTRL_AN_EN]; // [RULE24]

endmodule : phy_autoneg_config_registers

// ---- testbench/mgmt_master.sv ----
/* Management master model: one-cycle write and read strobes on mclk.
   Assumes read data is valid the cycle after the strobe is taken. */
`timescale 1ns/100ps
module mgmt_master (
  // Clock
  input logic mclk,
  // Management port
  output logic [4:0] mgmt_addr,
  output logic [15:0] mgmt_wdata,
  output logic mgmt_write,
  output logic mgmt_read,
  input logic [15:0] mgmt_rdata
);
  // Idle bus from time zero
  initial begin
    {mgmt_addr, mgmt_wdata, mgmt_write, mgmt_read} = 23'h00_0000;
  end
  // Reserved advert bits leave as zero; data is inverted once released
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk);
    mgmt_addr <= a;
    mgmt_wdata <= (a == 5'h04) ? (d & 16'he7ff) : d;
    mgmt_write <= 1'b1;
    @(posedge mclk);
    mgmt_write <= 1'b0;
    mgmt_wdata <= ~mgmt_wdata;
  endtask : wr
  // Data is taken one edge after the strobe was seen
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge mclk);
    mgmt_addr <= a;
    mgmt_read <= 1'b1;
    @(posedge mclk);
    mgmt_read <= 1'b0;
    @(posedge mclk);
    d = mgmt_rdata;
  endtask : rd
endmodule : mgmt_master

// ---- testbench/phy_an_asserts.sv ----
/* Port checks for the negotiation register bank.
   Assumes rising mclk and an asynchronous active-low rstn. */
`timescale 1ns/100ps
module phy_an_asserts
  import phy_an_pkg::*;
(
  // Clock and reset
  input logic mclk,
  input logic rstn,
  // Management port
  input logic [4:0] mgmt_addr,
  input logic [15:0] mgmt_wdata,
  input logic mgmt_write,
  input logic mgmt_read,
  input logic [15:0] mgmt_rdata,
  input logic mgmt_rvalid,
  // Engine side and controls
  input logic an_page_valid,
  input logic [15:0] an_page_word,
  input logic an_tx_ack,
  input logic an_pd_fault,
  input logic an_complete,
  input logic [3:0] an_result,
  input logic [15:0] adv_tx_word,
  input ctrl_t ctrl
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  logic [15:0] last_page;
  logic [7:0] hi_cnt;
  // Last page the engine offered; the partner register must mirror it
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      last_page <= 16'h0000;
    end else if (an_page_valid) begin
      last_page <= an_page_word;
    end
  end
  // Width of the running machine reset pulse, so a dip mid-pulse shows up
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hi_cnt <= 8'h00;
    end else if (ctrl.state_machine_reset) begin
      hi_cnt <= hi_cnt + 8'h01;
    end else begin
      hi_cnt <= 8'h00;
    end
  end
  // A cycle with no expansion read, so no clear-on-read slips in between
  sequence s_gap;
    !(mgmt_read && mgmt_addr == 5'h06);
  endsequence
  // Completion while enabled, not followed by a second completion
  sequence s_done;
    (an_complete && ctrl.an_enable) ##1 !an_complete;
  endsequence
  // Expansion read with no event racing the clear-on-read
  sequence s_rdx;
    mgmt_read && mgmt_addr == 5'h06 && !an_page_valid && !an_pd_fault;
  endsequence
  property p_np;
    adv_tx_word[15] == 1'b0 && adv_tx_word[9] == 1'b0;
  endproperty
  a_np: assert property (p_np) else $error("fixed zero bit set");
  property p_ack;
    $past(rstn) |-> adv_tx_word[14] == $past(an_tx_ack);
  endproperty
  a_ack: assert property (p_ack) else $error("ack not followed");
  property p_exp_rsvd;
    s_rdx |=> mgmt_rvalid && mgmt_rdata[15:5] == 11'h000 && !mgmt_rdata[2];
  endproperty
  a_exp_rsvd: assert property (p_exp_rsvd) else $error("exp bits");
  property p_page;
    an_page_valid ##1 s_gap ##1 s_rdx |=> mgmt_rdata[1:0] == 2'h3;
  endproperty
  a_page: assert property (p_page) else $error("page flags");
  // Second read after a quiet gap must find the sticky flags cleared
  property p_clear;
    s_rdx ##1 (!an_page_valid && !an_pd_fault)[*2] ##1 s_rdx
      |=> !mgmt_rdata[1] && !mgmt_rdata[4];
  endproperty
  a_clear: assert property (p_clear) else $error("flag kept");
  property p_pdf;
    an_pd_fault ##1 s_gap ##1 s_rdx |=> mgmt_rdata[4];
  endproperty
  a_pdf: assert property (p_pdf) else $error("fault lost");
  property p_state_machine_reset;
    $rose(ctrl.state_machine_reset) |-> ctrl.state_machine_reset[*8]
      ##17 ctrl.state_machine_reset ##1 !ctrl.state_machine_reset;
  endproperty
  a_state_machine_reset: assert property (p_state_machine_reset) else $error("reset pulse");
  property p_vcfg;
    mgmt_write && mgmt_addr == 5'h10 |=> ctrl.copper_mode ==
      $past(mgmt_wdata[10]) && ctrl.remote_loopback == $past(mgmt_wdata[0]);
  endproperty
  a_vcfg: assert property (p_vcfg) else $error("vendor ctrl");
  property p_partner;
    (mgmt_read && mgmt_addr == 5'h05 && !an_page_valid) |=>
      mgmt_rdata == (last_page & 16'he7ff);
  endproperty
  a_partner: assert property (p_partner) else $error("partner word");
  property p_result;
    s_done ##1 (mgmt_read && mgmt_addr == 5'h11 && !an_complete) |=>
      mgmt_rdata[15:12] == $past(an_result, 3);
  endproperty
  a_result: assert property (p_result) else $error("mode lost");
  property p_state_machine_reset_len;
    $fell(ctrl.state_machine_reset) |-> hi_cnt == 8'h19;
  endproperty
  a_state_machine_reset_len: assert property (p_state_machine_reset_len) else $error("pulse width");
endmodule : phy_an_asserts

bind phy_autoneg_config_registers phy_an_asserts u_chk (
  .mclk(mclk), .rstn(rstn), .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata),
  .mgmt_write(mgmt_write), .mgmt_read(mgmt_read), .mgmt_rdata(mgmt_rdata),
  .mgmt_rvalid(mgmt_rvalid), .an_page_valid(an_page_valid),
  .an_page_word(an_page_word), .an_tx_ack(an_tx_ack),
  .an_pd_fault(an_pd_fault), .an_complete(an_complete),
  .an_result(an_result), .adv_tx_word(adv_tx_word), .ctrl(ctrl));

// ---- testbench/phy_autoneg_config_registers_tb_top.sv ----
/* Bench for the negotiation register bank: master model on the
   management port, engine events from here, xorshift data.
   Assumes the bank, its checker and the master model are compiled. */
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module phy_autoneg_config_registers_tb_top
  import phy_an_pkg::*;
;
  logic mclk, rstn, mgmt_write, mgmt_read, mgmt_rvalid;
  logic an_page_valid, an_tx_ack, an_pd_fault, an_complete;
  logic [4:0] mgmt_addr;
  logic [3:0] an_result;
  logic [15:0] mgmt_wdata, mgmt_rdata, an_page_word, adv_tx_word, rv, w;
  logic [31:0] seed = 32'h0000_2bb3;
  ctrl_t ctrl;
  int fails = 0, cmp_count = 0, cyc = 0;
  // Fixed start so every run repeats
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction : rnd
  // Control levels a vendor word should give, negotiation enabled
  function automatic ctrl_t exp_ctrl(input logic [15:0] v);
    return {v[15:12], v[10], v[7], v[4], v[3], v[1], v[0], 1'b1};
  endfunction : exp_ctrl
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  mgmt_master mm (.mclk(mclk), .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata),
    .mgmt_write(mgmt_write), .mgmt_read(mgmt_read), .mgmt_rdata(mgmt_rdata));
  phy_autoneg_config_registers uut (.mclk(mclk), .rstn(rstn),
    .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_write(mgmt_write),
    .mgmt_read(mgmt_read), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
    .an_page_valid(an_page_valid), .an_page_word(an_page_word),
    .an_tx_ack(an_tx_ack), .an_pd_fault(an_pd_fault),
    .an_complete(an_complete), .an_result(an_result),
    .adv_tx_word(adv_tx_word), .ctrl(ctrl));
  // One-cycle engine pulse; word and result are inverted once stale
  task automatic ev(input logic [2:0] k, input logic [15:0] d,
                    input logic [3:0] r);
    @(posedge mclk);
    {an_complete, an_pd_fault, an_page_valid} <= k;
    an_page_word <= d;
    an_result <= r;
    @(posedge mclk);
    {an_complete, an_pd_fault, an_page_valid} <= 3'h0;
    an_page_word <= ~d;
    an_result <= ~r;
  endtask : ev
  // Masked read compare
  task automatic rc(input logic [4:0] a, input logic [15:0] m, e);
    mm.rd(a, rv);
    `CHK(rv & m, e)
  endtask : rc
  task automatic print_verdict();
    if (fails == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  // Whole run needs well under a thousand cycles; a hang ends here
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      print_verdict();
    end
  end
  initial begin
    rstn = 1'b0;
    {an_page_valid, an_pd_fault, an_complete, an_tx_ack} = 4'h0;
    an_page_word = 16'h0000;
    an_result = 4'h0;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    // Reset values; reserved advert bits are ignored on read
    rc(5'h04, 16'he7ff, 16'h05e1);
    rc(5'h05, 16'hffff, 16'h0000);
    rc(5'h06, 16'hffff, 16'h0000);
    rc(5'h10, 16'hffff, 16'h0414);
    rc(5'h11, 16'hffff, 16'hf000);
    rc(5'h00, 16'hffff, 16'h3100);
    rc(5'h1f, 16'hffff, 16'h0000);
    `CHK(ctrl, exp_ctrl(16'h0414))
    // Advert corners then random words, trying the fixed bits too
    for (int i = 0; i < 6; i++) begin
      w = (i < 2) ? {16{i[0]}} : rnd();
      an_tx_ack <= w[0];
      mm.wr(5'h04, w);
      rc(5'h04, 16'ha7ff, w & 16'h25ff);
      `CHK(adv_tx_word, (w & 16'h25ff) | {1'b0, w[0], 14'h0000})
    end
    an_tx_ack <= 1'b1;
    repeat (2) @(posedge mclk);
    `CHK(adv_tx_word[15:14], 2'h1)
    // Partner pages; sticky flags clear on read, writes are ignored
    repeat (3) begin
      w = rnd();
      ev(3'h1, w, 4'h0);
      rc(5'h06, 16'hffff, {12'h000, w[15], 3'h3});
      rc(5'h06, 16'hffff, {12'h000, w[15], 3'h1});
      mm.wr(5'h05, ~w);
      rc(5'h05, 16'hffff, w & 16'he7ff);
    end
    ev(3'h2, w, 4'h0);
    rc(5'h06, 16'h0010, 16'h0010);
    rc(5'h06, 16'h0010, 16'h0000);
    // Vendor controls; reset and sleep bits are exercised below
    repeat (4) begin
      w = rnd() & 16'hfdf5;
      mm.wr(5'h10, w);
      @(negedge mclk);
      `CHK(ctrl, exp_ctrl(w))
      rc(5'h10, 16'hffff, w);
    end
    mm.wr(5'h10, 16'h0008);
    rc(5'h10, 16'h0008, 16'h0008);
    repeat (30) @(posedge mclk);
    rc(5'h10, 16'h0008, 16'h0000);
    mm.wr(5'h10, 16'h0002);
    @(negedge mclk);
    `CHK({ctrl.sleep_mode, ctrl.state_machine_reset}, 2'h2)
    mm.wr(5'h10, 16'h0000);
    @(negedge mclk);
    `CHK({ctrl.sleep_mode, ctrl.state_machine_reset}, 2'h1)
    repeat (30) @(posedge mclk);
    // Every negotiated mode, then a result while disabled is dropped
    for (int i = 0; i < 4; i++) begin
      ev(3'h4, w, 4'h1 << i);
      rc(5'h11, 16'hffff, {4'h1 << i, 12'h000});
      rc(5'h00, 16'h3100, {2'h0, i >= 2, 4'h8, i[0], 8'h00});
    end
    mm.wr(5'h00, 16'h0000);
    ev(3'h4, w, 4'h1);
    `CHK(ctrl.an_enable, 1'b0)
    rc(5'h11, 16'hffff, 16'h8000);
    rc(5'h00, 16'hffff, 16'h0000);
    print_verdict();
  end
endmodule : phy_autoneg_config_registers_tb_top
